// >>> dmi_defs.svh
// constants of the data-move executor: bus map, field codes, reset values
// assumes inclusion by bare name from the package and the executor module
`ifndef DMI_DEFS_SVH
`define DMI_DEFS_SVH

// pointer mode field codes
`define DMI_MM_PREINC 2'h0
`define DMI_MM_PREDEC 2'h1
`define DMI_MM_POSTINC 2'h2
`define DMI_MM_POSTDEC 2'h3

// file addresses of the two indirect windows
`define DMI_WIN0_ADDR 7'h00
`define DMI_WIN1_ADDR 7'h01

// register bus: bit 15 selects core registers, index in bits 2:0
`define DMI_CORE_SEL_BIT 15
`define DMI_IDX_W 3'h0
`define DMI_IDX_PTR0_LO 3'h1
`define DMI_IDX_PTR0_HI 3'h2
`define DMI_IDX_PTR1_LO 3'h3
`define DMI_IDX_PTR1_HI 3'h4
`define DMI_IDX_BANK 3'h5
`define DMI_IDX_PCH 3'h6
`define DMI_IDX_STATUS 3'h7

// reset values
`define DMI_W_RST 8'h00
`define DMI_PTR_RST 16'h0000
`define DMI_BANK_RST 5'h00
`define DMI_PCH_RST 7'h00

// clocks per instruction cycle
`define DMI_INSTR_CLKS 2

`endif

// >>> dmi_pkg.sv
// types shared by the data-move executor and its users
// assumes dmi_defs.svh sits in the include path
package dmi_pkg;
    `include "dmi_defs.svh"

    typedef enum logic [2:0] {
        OP_NONE,
        OP_IND_TO_W,
        OP_W_TO_IND,
        OP_BANK_LIT,
        OP_PCH_LIT,
        OP_W_LIT,
        OP_W_TO_FILE
    } dmi_op_e;

    typedef logic [1:0] dmi_mode_t;

    typedef struct packed {
        dmi_op_e op;
        logic ptr_sel;
        logic relative;
        dmi_mode_t mode;
        logic [5:0] offset;
        logic [7:0] literal;
        logic [6:0] faddr;
    } dmi_instr_s;

    typedef enum logic {
        ST_ISSUE,
        ST_FINISH
    } dmi_state_e;
endpackage : dmi_pkg

// >>> dmi_mem.sv
// dual-port byte memory behind the executor, read data registered
// assumes one clock; on a same-address double write port a wins
module dmi_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // core port
    input wire logic [AW-1:0] i_a_addr,
    input wire logic i_a_we,
    input wire logic [DW-1:0] i_a_wdata,
    output logic [DW-1:0] o_a_rdata,
    // bus port
    input wire logic [AW-1:0] i_b_addr,
    input wire logic i_b_we,
    input wire logic [DW-1:0] i_b_wdata,
    output logic [DW-1:0] o_b_rdata
);
    logic [DW-1:0] cells [0:(1<<AW)-1];

    initial begin
        if (AW < 1 || AW > 14 || DW < 1) begin
            $error("dmi_mem: unsupported size");
        end
    end

    // cells hold no reset; only the read registers are cleared
    always_ff @(posedge i_clk) begin
        if (i_b_we) begin
            cells[i_b_addr] <= i_b_wdata;
        end
        if (i_a_we) begin
            cells[i_a_addr] <= i_a_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_a_rdata <= '0;
            o_b_rdata <= '0;
        end else begin
            o_a_rdata <= cells[i_a_addr];
            o_b_rdata <= cells[i_b_addr];
        end
    end
endmodule : dmi_mem

// >>> dmi_exec.sv
// executor for the indirect and literal data-move instruction group
// assumes a sequencer on i_clk that offers one decoded instruction at a time
// and a software port on the same clock that never overlaps its strobes
`include "dmi_defs.svh"

// Contract
// RQ1: indirect read copies pointed byte into working
// RQ2: window access redirected through pointer, no cell
// RQ3: mode codes: 00 pre+,01 pre-,10 post+,11 post-
// RQ4: pre-increment uses and keeps pointer plus one
// RQ5: pre-decrement uses and keeps pointer minus one
// RQ6: post-increment uses pointer, then adds one
// RQ7: post-decrement uses pointer, then subtracts one
// RQ8: relative offset -32..31, pointer unchanged
// RQ9: pointer steps wrap modulo sixteen bits
// RQ10: indirect write stores working, same modes
// RQ11: bank literal load, five bits, flags kept
// RQ12: pc high literal load, seven bits, flags kept
// RQ13: working literal load, eight bits, flags kept
// RQ14: working to file register, flags kept
// RQ15: pointer steps never touch status
// RQ16: one word, one instruction cycle each
module dmi_exec #(
    parameter int MEM_AW = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // instruction handshake
    input wire logic i_valid,
    input wire dmi_pkg::dmi_instr_s i_instr,
    output logic o_ready,
    output logic o_done,
    // software register port
    input wire logic [15:0] i_bus_addr,
    input wire logic [7:0] i_bus_wdata,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    output logic [7:0] o_bus_rdata,
    // architectural state
    output logic [7:0] o_w,
    output logic [15:0] o_ptr0,
    output logic [15:0] o_ptr1,
    output logic [4:0] o_bsr,
    output logic [6:0] o_pc_high_latch,
    output logic o_zero
);
    import dmi_pkg::*;

    initial begin
        if (MEM_AW < 1 || MEM_AW > 14) begin
            $error("dmi_exec: MEM_AW must be 1..14");
        end
    end

    // pre modes step before the access, post modes after it
    function automatic logic [15:0] step_ptr(input logic [15:0] p,
                                             input dmi_mode_t mm);
        step_ptr = mm[0] ? p - 16'h0001 : p + 16'h0001; // [RQ3] [RQ9]
    endfunction : step_ptr

    function automatic logic [15:0] eff_addr(input logic [15:0] p,
                                             input dmi_instr_s ins);
        logic [15:0] off;
        off = {{10{ins.offset[5]}}, ins.offset};
        if (ins.relative) begin
            eff_addr = p + off; // [RQ8]
        end else if (ins.mode[1]) begin
            eff_addr = p; // [RQ6] [RQ7]
        end else begin
            eff_addr = step_ptr(p, ins.mode); // [RQ4] [RQ5]
        end
    endfunction : eff_addr

    dmi_state_e state;
    dmi_state_e next_state;
    logic rd_pend;
    logic bus_core_q;
    logic [7:0] bus_reg_q;
    logic bus_hit_q;

    // decode of the offered instruction
    wire logic accept = i_valid && o_ready;
    wire logic op_rd = i_instr.op == OP_IND_TO_W;
    wire logic op_wr = i_instr.op == OP_W_TO_IND;
    wire logic op_file = i_instr.op == OP_W_TO_FILE;
    wire logic is_ind = op_rd || op_wr;
    wire logic acc_ind = accept && is_ind;
    wire logic acc_bank = accept && i_instr.op == OP_BANK_LIT;
    wire logic acc_pch = accept && i_instr.op == OP_PCH_LIT;
    wire logic acc_wlit = accept && i_instr.op == OP_W_LIT;

    // pointer arithmetic
    wire logic [15:0] sel_ptr = i_instr.ptr_sel ? o_ptr1 : o_ptr0;
    wire logic [15:0] ind_addr = eff_addr(sel_ptr, i_instr);
    wire logic [15:0] new_ptr = i_instr.relative ? sel_ptr :
                                step_ptr(sel_ptr, i_instr.mode);

    // a direct access to a window is a pointer access with no step
    wire logic win0 = i_instr.faddr == `DMI_WIN0_ADDR;
    wire logic win1 = i_instr.faddr == `DMI_WIN1_ADDR;
    wire logic [15:0] file_addr = win1 ? o_ptr1 :
                                  win0 ? o_ptr0 :
                                  {4'h0, o_bsr, i_instr.faddr}; // [RQ2]
    wire logic [15:0] core_addr16 = is_ind ? ind_addr : file_addr; // [RQ2]
    wire logic [MEM_AW-1:0] core_addr = core_addr16[MEM_AW-1:0];
    wire logic core_we = accept && (op_wr || op_file); // [RQ10] [RQ14]
    wire logic [7:0] core_rd;

    // software port decode
    wire logic bus_core = i_bus_addr[`DMI_CORE_SEL_BIT] &&
                          i_bus_addr[14:3] == 12'h000;
    wire logic bus_mem = !i_bus_addr[`DMI_CORE_SEL_BIT] &&
                         i_bus_addr[14:MEM_AW] == '0;
    wire logic [2:0] bus_idx = i_bus_addr[2:0];
    wire logic bus_cw = i_bus_wr && bus_core;
    wire logic [7:0] bus_mem_rd;
    wire logic [7:0] status_byte = {6'h00, o_ready, o_zero};
    logic [7:0] core_view;

    always_comb begin
        core_view = 8'h00;
        unique case (bus_idx)
            `DMI_IDX_W: core_view = o_w;
            `DMI_IDX_PTR0_LO: core_view = o_ptr0[7:0];
            `DMI_IDX_PTR0_HI: core_view = o_ptr0[15:8];
            `DMI_IDX_PTR1_LO: core_view = o_ptr1[7:0];
            `DMI_IDX_PTR1_HI: core_view = o_ptr1[15:8];
            `DMI_IDX_BANK: core_view = {3'h0, o_bsr};
            `DMI_IDX_PCH: core_view = {1'h0, o_pc_high_latch};
            `DMI_IDX_STATUS: core_view = status_byte;
        endcase
    end

    dmi_mem #(
        .AW(MEM_AW),
        .DW(8)
    ) u_mem (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_a_addr(core_addr),
        .i_a_we(core_we),
        .i_a_wdata(o_w), // [RQ10] [RQ14]
        .o_a_rdata(core_rd),
        .i_b_addr(i_bus_addr[MEM_AW-1:0]),
        .i_b_we(i_bus_wr && bus_mem),
        .i_b_wdata(i_bus_wdata),
        .o_b_rdata(bus_mem_rd)
    );

    // every instruction takes the same fixed two-clock cycle so that
    // the sequencer never has to know which kind it issued
    always_comb begin
        next_state = state;
        unique case (state)
            ST_ISSUE: if (accept) next_state = ST_FINISH; // [RQ16]
            ST_FINISH: next_state = ST_ISSUE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_ISSUE;
            o_ready <= 1'b1;
            o_done <= 1'b0;
            rd_pend <= 1'b0;
        end else begin
            state <= next_state;
            o_ready <= next_state == ST_ISSUE;
            o_done <= state == ST_FINISH; // [RQ16]
            rd_pend <= accept && op_rd;
        end
    end

    // working register: memory byte lands one clock after the access
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_w <= `DMI_W_RST;
        end else if (rd_pend) begin
            o_w <= core_rd; // [RQ1]
        end else if (acc_wlit) begin
            o_w <= i_instr.literal; // [RQ13]
        end else if (bus_cw && bus_idx == `DMI_IDX_W) begin
            o_w <= i_bus_wdata;
        end
    end

    // only the indirect read moves the zero flag
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_zero <= 1'b0;
        end else if (rd_pend) begin
            o_zero <= core_rd == 8'h00; // [RQ15]
        end
    end

    // an instruction step wins over a software write in the same clock
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ptr0 <= `DMI_PTR_RST;
        end else if (acc_ind && !i_instr.ptr_sel) begin
            o_ptr0 <= new_ptr; // [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9]
        end else if (bus_cw && bus_idx == `DMI_IDX_PTR0_LO) begin
            o_ptr0[7:0] <= i_bus_wdata;
        end else if (bus_cw && bus_idx == `DMI_IDX_PTR0_HI) begin
            o_ptr0[15:8] <= i_bus_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ptr1 <= `DMI_PTR_RST;
        end else if (acc_ind && i_instr.ptr_sel) begin
            o_ptr1 <= new_ptr; // [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9]
        end else if (bus_cw && bus_idx == `DMI_IDX_PTR1_LO) begin
            o_ptr1[7:0] <= i_bus_wdata;
        end else if (bus_cw && bus_idx == `DMI_IDX_PTR1_HI) begin
            o_ptr1[15:8] <= i_bus_wdata;
        end
    end

    // upper literal bits are ignored for the narrow loads
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bsr <= `DMI_BANK_RST;
        end else if (acc_bank) begin
            o_bsr <= i_instr.literal[4:0]; // [RQ11]
        end else if (bus_cw && bus_idx == `DMI_IDX_BANK) begin
            o_bsr <= i_bus_wdata[4:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pc_high_latch <= `DMI_PCH_RST;
        end else if (acc_pch) begin
            o_pc_high_latch <= i_instr.literal[6:0]; // [RQ12]
        end else if (bus_cw && bus_idx == `DMI_IDX_PCH) begin
            o_pc_high_latch <= i_bus_wdata[6:0];
        end
    end

    // read data: core view captured here, memory byte from its own register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bus_core_q <= 1'b0;
            bus_hit_q <= 1'b0;
            bus_reg_q <= 8'h00;
        end else begin
            bus_core_q <= bus_core;
            bus_hit_q <= i_bus_rd && (bus_core || bus_mem);
            bus_reg_q <= core_view;
        end
    end

    // unmapped or idle reads answer zero
    assign o_bus_rdata = !bus_hit_q ? 8'h00 :
                         bus_core_q ? bus_reg_q : bus_mem_rd;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    wire logic chk_p0 = acc_ind && !i_instr.ptr_sel && !i_instr.relative;

    property p_read_to_w;
        accept && op_rd |=> ##1 (o_w == $past(core_rd) && o_done);
    endproperty
    a_read_to_w: assert property (p_read_to_w) // [RQ1]
        else $error("indirect read did not reach working");

    property p_window_redirect;
        accept && op_file && win0 |-> core_addr16 == o_ptr0 && core_we;
    endproperty
    a_window_redirect: assert property (p_window_redirect) // [RQ2]
        else $error("window access not redirected");

    property p_preinc;
        chk_p0 && i_instr.mode == `DMI_MM_PREINC
        |-> core_addr16 == o_ptr0 + 16'h0001
        ##1 o_ptr0 == $past(o_ptr0) + 16'h0001;
    endproperty
    a_preinc: assert property (p_preinc) // [RQ4]
        else $error("pre-increment wrong");

    property p_predec;
        chk_p0 && i_instr.mode == `DMI_MM_PREDEC
        |-> core_addr16 == o_ptr0 - 16'h0001
        ##1 o_ptr0 == $past(o_ptr0) - 16'h0001;
    endproperty
    a_predec: assert property (p_predec) // [RQ5]
        else $error("pre-decrement wrong");

    property p_postinc;
        chk_p0 && i_instr.mode == `DMI_MM_POSTINC
        |-> core_addr16 == o_ptr0
        ##1 o_ptr0 == $past(o_ptr0) + 16'h0001;
    endproperty
    a_postinc: assert property (p_postinc) // [RQ6]
        else $error("post-increment wrong");

    property p_postdec;
        chk_p0 && i_instr.mode == `DMI_MM_POSTDEC
        |-> core_addr16 == o_ptr0
        ##1 o_ptr0 == $past(o_ptr0) - 16'h0001;
    endproperty
    a_postdec: assert property (p_postdec) // [RQ7]
        else $error("post-decrement wrong");

    property p_relative;
        acc_ind && i_instr.ptr_sel && i_instr.relative
        |-> core_addr16 == o_ptr1 + {{10{i_instr.offset[5]}}, i_instr.offset}
        ##1 $stable(o_ptr1);
    endproperty
    a_relative: assert property (p_relative) // [RQ8]
        else $error("relative mode wrong");

    property p_wrap;
        chk_p0 && (i_instr.mode[0] ? o_ptr0 == 16'h0000 : o_ptr0 == 16'hFFFF)
        |=> o_ptr0 == ($past(i_instr.mode[0]) ? 16'hFFFF : 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) // [RQ9]
        else $error("pointer did not wrap");

    property p_write_ind;
        accept && op_wr |-> core_we ##1 u_mem.cells[$past(core_addr)] == $past(o_w);
    endproperty
    a_write_ind: assert property (p_write_ind) // [RQ10]
        else $error("indirect write missing");

    property p_bank;
        acc_bank |=> o_bsr == $past(i_instr.literal[4:0]) && $stable(o_zero);
    endproperty
    a_bank: assert property (p_bank) // [RQ11]
        else $error("bank literal load wrong");

    property p_pch;
        acc_pch |=> o_pc_high_latch == $past(i_instr.literal[6:0]) && $stable(o_zero);
    endproperty
    a_pch: assert property (p_pch) // [RQ12]
        else $error("pc high literal load wrong");

    property p_wlit;
        acc_wlit |=> o_w == $past(i_instr.literal) ##1 $stable(o_zero);
    endproperty
    a_wlit: assert property (p_wlit) // [RQ13]
        else $error("working literal load wrong");

    property p_file;
        accept && op_file |-> core_we ##1 $stable(o_zero);
    endproperty
    a_file: assert property (p_file) // [RQ14]
        else $error("file write wrong");

    property p_step_no_flag;
        accept && op_wr |=> $stable(o_zero) [*2];
    endproperty
    a_step_no_flag: assert property (p_step_no_flag) // [RQ15]
        else $error("pointer step touched status");

    property p_one_cycle;
        accept |=> !o_ready && !o_done ##1 o_ready && o_done;
    endproperty
    a_one_cycle: assert property (p_one_cycle) // [RQ16]
        else $error("instruction cycle length wrong");
endmodule : dmi_exec

// >>> tb.sv
// self-checking bench for the data-move executor, memory shrunk to 16 bytes
// assumes dmi_pkg and dmi_exec are compiled first; checks sit in the design
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dmi_pkg::*;

    localparam int AW = 4;

    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_valid = 1'b0;
    dmi_instr_s i_instr = '0;
    logic [15:0] i_bus_addr = 16'h0000;
    logic [7:0] i_bus_wdata = 8'h00;
    logic i_bus_wr = 1'b0;
    logic i_bus_rd = 1'b0;
    logic o_ready;
    logic o_done;
    logic o_zero;
    logic [7:0] o_bus_rdata;
    logic [7:0] o_w;
    logic [15:0] o_ptr0;
    logic [15:0] o_ptr1;
    logic [4:0] o_bsr;
    logic [6:0] o_pc_high_latch;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] rnd = 16'h0009;
    // reference state kept by the bench
    logic [7:0] m_mem [16];
    logic [7:0] m_w = 8'h00;
    logic [15:0] m_ptr [2];
    logic [4:0] m_bsr = 5'h00;
    logic [6:0] m_pch = 7'h00;
    logic m_zero = 1'b0;

    dmi_exec #(.MEM_AW(AW)) dut_u (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_valid(i_valid), .i_instr(i_instr),
        .o_ready(o_ready), .o_done(o_done), .i_bus_addr(i_bus_addr),
        .i_bus_wdata(i_bus_wdata), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd),
        .o_bus_rdata(o_bus_rdata), .o_w(o_w), .o_ptr0(o_ptr0), .o_ptr1(o_ptr1),
        .o_bsr(o_bsr), .o_pc_high_latch(o_pc_high_latch), .o_zero(o_zero)
    );

    initial begin
        forever #2.5 i_clk = ~i_clk;
    end

    function automatic logic [15:0] next_rnd(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : next_rnd

    // plain 16-bit arithmetic, so both ends of the range wrap
    function automatic logic [15:0] step(input logic [15:0] p, input logic dn);
        return dn ? p - 16'h0001 : p + 16'h0001;
    endfunction : step

    function automatic logic [15:0] eff_of(input dmi_instr_s s, input logic [15:0] p);
        if (s.relative) begin
            return p + {{10{s.offset[5]}}, s.offset};
        end
        return s.mode[1] ? p : step(p, s.mode[0]);
    endfunction : eff_of

    function automatic logic [15:0] ptr_after(input dmi_instr_s s, input logic [15:0] p);
        return s.relative ? p : step(p, s.mode[0]);
    endfunction : ptr_after

    // software view of the core registers, from the reference state;
    // status assumes no instruction is in flight, so ready reads as one
    function automatic logic [7:0] core_exp(input logic [2:0] idx);
        case (idx)
            3'h0: return m_w;
            3'h1: return m_ptr[0][7:0];
            3'h2: return m_ptr[0][15:8];
            3'h3: return m_ptr[1][7:0];
            3'h4: return m_ptr[1][15:8];
            3'h5: return {3'h0, m_bsr};
            3'h6: return {1'h0, m_pch};
            default: return {6'h00, 1'b1, m_zero};
        endcase
    endfunction : core_exp

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (exp !== got) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_bus_wr <= 1'b1;
        i_bus_addr <= a;
        i_bus_wdata <= d;
        @(posedge i_clk);
        i_bus_wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_bus_rd <= 1'b1;
        i_bus_addr <= a;
        @(posedge i_clk);
        i_bus_rd <= 1'b0;
        @(negedge i_clk);
        d = o_bus_rdata;
    endtask : bus_rd

    task automatic set_ptr(input logic sel, input logic [15:0] v);
        bus_wr(16'h8001 + {14'h0000, sel, 1'b0}, v[7:0]);
        bus_wr(16'h8002 + {14'h0000, sel, 1'b0}, v[15:8]);
        m_ptr[sel] = v;
    endtask : set_ptr

    task automatic check_state();
        check("w", m_w, o_w);
        check("ptr0", m_ptr[0], o_ptr0);
        check("ptr1", m_ptr[1], o_ptr1);
        check("bank", m_bsr, o_bsr);
        check("pc high", m_pch, o_pc_high_latch);
        check("zero", m_zero, o_zero);
    endtask : check_state

    // offers one instruction, updates the reference and checks its timing
    task automatic run(input dmi_instr_s s);
        logic [15:0] ea;
        int n;
        @(posedge i_clk);
        i_valid <= 1'b1;
        i_instr <= s;
        n = 0;
        @(negedge i_clk);
        while (o_ready !== 1'b1 && n < 8) begin
            @(negedge i_clk);
            n++;
        end
        @(posedge i_clk);
        i_valid <= 1'b0;
        case (s.op)
            OP_IND_TO_W, OP_W_TO_IND: begin
                ea = eff_of(s, m_ptr[s.ptr_sel]);
                if (s.op == OP_IND_TO_W) begin
                    m_w = m_mem[ea[3:0]];
                    m_zero = (m_w == 8'h00);
                end else begin
                    m_mem[ea[3:0]] = m_w;
                end
                m_ptr[s.ptr_sel] = ptr_after(s, m_ptr[s.ptr_sel]);
            end
            OP_BANK_LIT: m_bsr = s.literal[4:0];
            OP_PCH_LIT: m_pch = s.literal[6:0];
            OP_W_LIT: m_w = s.literal;
            OP_W_TO_FILE: begin
                ea = (s.faddr == 7'h00 || s.faddr == 7'h01) ? m_ptr[s.faddr[0]]
                                                             : {4'h0, m_bsr, s.faddr};
                m_mem[ea[3:0]] = m_w;
            end
            default: ;
        endcase
        @(negedge i_clk);
        check("ready busy", 16'h0000, o_ready);
        check("done early", 16'h0000, o_done);
        @(negedge i_clk);
        check("done", 16'h0001, o_done);
        check_state();
    endtask : run

    initial begin
        logic [7:0] rd;
        dmi_instr_s s;
        m_ptr[0] = 16'h0000;
        m_ptr[1] = 16'h0000;
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(negedge i_clk);
        check_state();
        check("ready", 16'h0001, o_ready);
        bus_rd(16'h8007, rd);
        check("status", 16'h0002, rd);
        // cell 5 is filled with zero so that the zero flag can be raised
        for (int i = 0; i < 16; i++) begin
            rnd = next_rnd(rnd);
            m_mem[i] = (i == 5) ? 8'h00 : rnd[7:0];
            bus_wr(16'(i), m_mem[i]);
        end
        bus_rd(16'h4000, rd);
        check("unmapped", 16'h0000, rd);
        // every mode on both pointers, started at both ends of the range
        for (int k = 0; k < 32; k++) begin
            s = '0;
            s.op = k[0] ? OP_W_TO_IND : OP_IND_TO_W;
            s.ptr_sel = k[1];
            s.mode = k[3:2];
            set_ptr(k[1], k[4] ? 16'hFFFF : 16'h0000);
            run(s);
        end
        // random pointers and offsets, extreme offsets first
        for (int k = 0; k < 24; k++) begin
            rnd = next_rnd(rnd);
            s = '0;
            s.op = rnd[0] ? OP_W_TO_IND : OP_IND_TO_W;
            s.ptr_sel = rnd[1];
            s.relative = (k % 3 == 0);
            s.mode = rnd[3:2];
            s.offset = (k == 0) ? 6'h20 : (k == 3) ? 6'h1F : rnd[9:4];
            set_ptr(s.ptr_sel, next_rnd(rnd));
            run(s);
        end
        // raise the zero flag, then literal loads and working-to-file writes must leave it alone
        s = '0;
        s.op = OP_IND_TO_W;
        s.relative = 1'b1;
        // the random writes may have hit cell 5, so clear it again first
        bus_wr(16'h0005, 8'h00);
        m_mem[5] = 8'h00;
        set_ptr(1'b0, 16'h0005);
        run(s);
        check("zero raised", 16'h0001, o_zero);
        for (int k = 0; k < 12; k++) begin
            rnd = next_rnd(rnd);
            s = '0;
            s.op = dmi_op_e'(3'(3 + k % 4));
            s.literal = (k < 4) ? 8'hFF : rnd[7:0];
            s.faddr = (k % 8 == 3) ? 7'h00 : (k % 8 == 7) ? 7'h01 : rnd[14:8];
            run(s);
        end
        s = '0;
        run(s);
        rnd = next_rnd(rnd);
        bus_wr(16'h8000, rnd[7:0]);
        m_w = rnd[7:0];
        bus_wr(16'h8005, rnd[15:8]);
        m_bsr = rnd[12:8];
        bus_wr(16'h8006, rnd[15:8]);
        m_pch = rnd[14:8];
        @(negedge i_clk);
        check_state();
        bus_rd(16'h8006, rd);
        check("pc high read", {9'h000, m_pch}, rd);
        for (int i = 0; i < 8; i++) begin
            bus_rd(16'h8000 + 16'(i), rd);
            check("core register", {8'h00, core_exp(3'(i))}, rd);
        end
        for (int i = 0; i < 16; i++) begin
            bus_rd(16'(i), rd);
            check("memory", m_mem[i], rd);
        end
        final_report();
    end
endmodule : tb
